/* edf_front.sv */
// Debug port front end: hot-plug detection, pin takeover, core reset hold,
// scan/wire mode switch, two parallel TAPs and the TDO mux.
// Assumes all pins asynchronous; TCK is oversampled by CLK (>= 8x).
module edf_front
    import edf_pkg::*;
(
    // Clock, reset, enable
    input  wire logic  CLK,
    input  wire logic  RST_N,
    input  wire logic  CE,
    // Debug pins
    input  wire logic  TCK,
    input  wire logic  TMS_IN,
    input  wire logic  TDI,
    input  wire logic  RESET_PIN_N,
    output logic       TDO_OUT,
    output logic       TDO_OE,
    // Downstream debug logic
    input  wire logic  DP_TDO,
    input  wire logic  TRACE_SER_OUT,
    input  wire logic  TRACE_EN,
    input  wire logic  SYSMGR_REQ_CLR,
    input  wire logic  [7:0] AP_SELECT,
    input  wire logic  DEEP_SAVE,
    output logic       BUS_AP_SEL,
    output logic       SYSMGR_AP_SEL,
    // System side
    output edf_pinown_type PIN_OWN,
    output logic       SCAN_MODE,
    output logic       DEBUG_PRESENT,
    output logic       CORE_RST_HOLD,
    output logic       CPU_CLK_REQ,
    output logic       POWER_KEEP,
    output logic       BSCAN_ACTIVE,
    output logic [3:0] IR_VALUE
);


    logic         tck_lvl, tms_lvl, tdi_lvl, rst_lvl;
    edf_edge_type tck_ev, tms_ev, tdi_ev, rst_ev;

    edf_sync u_tck (.clk(CLK), .rst_n(RST_N), .ce(CE), .async_in(TCK),
                    .level(tck_lvl), .edge_ev(tck_ev));
    edf_sync u_tms (.clk(CLK), .rst_n(RST_N), .ce(CE), .async_in(TMS_IN),
                    .level(tms_lvl), .edge_ev());
    edf_sync u_tdi (.clk(CLK), .rst_n(RST_N), .ce(CE), .async_in(TDI),
                    .level(tdi_lvl), .edge_ev());
    edf_sync u_rst (.clk(CLK), .rst_n(RST_N), .ce(CE), .async_in(RESET_PIN_N),
                    .level(rst_lvl), .edge_ev(rst_ev));

    // Presence, core reset hold and mode state
    logic        present_reg, present_next;
    logic        hold_reg, hold_next;
    logic        wire_reg, wire_next;
    logic [15:0] sh_reg, sh_next;
    logic [5:0]  hi_reg, hi_next;
    logic [1:0]  pend_reg, pend_next;       // 01 to wire, 10 to scan
    logic [5:0]  post_reg, post_next;
    edf_tap_type tap_reg, tap_next;
    logic [3:0]  irs_reg, irs_next;
    logic [3:0]  ir_reg, ir_next;
    logic        byp_reg, byp_next;
    logic        tdo_reg, tdo_next;
    logic        oe_reg, oe_next;
    logic        front_rst;
    logic [5:0]  pre_reg, pre_next;
    logic        pre_ok;

    assign front_rst = (tap_reg == TAP_RESET);

    always_comb begin
        present_next = present_reg;
        hold_next    = hold_reg;
        if (tck_ev.fall && rst_lvl && !DEEP_SAVE)
            present_next = 1'b1;
        if (rst_ev.rise && !tck_lvl)
            hold_next = 1'b1;
        else if (SYSMGR_REQ_CLR && rst_lvl)
            hold_next = 1'b0;
        if (!rst_lvl)
            present_next = 1'b0;
    end

    // Mode switch detector on TCK rising edges
    always_comb begin
        sh_next   = sh_reg;
        hi_next   = hi_reg;
        pend_next = pend_reg;
        post_next = post_reg;
        wire_next = wire_reg;
        if (tck_ev.rise && present_reg) begin
            sh_next = {sh_reg[14:0], tms_lvl};
            if (tms_lvl) begin
                if (hi_reg != 6'(SEQ_HIGH_MIN + 1))
                    hi_next = hi_reg + 6'h01;
            end else begin
                hi_next = 6'h00;
            end
            if (pend_reg != 2'h0) begin
                if (!tms_lvl) begin
                    pend_next = 2'h0;
                    post_next = 6'h00;
                end else if (post_reg == 6'(SEQ_HIGH_MIN)) begin
                    wire_next = pend_reg[0];
                    pend_next = 2'h0;
                    post_next = 6'h00;
                end else begin
                    post_next = post_reg + 6'h01;
                end
            end
            if (sh_next == SEQ_TO_WIRE && !wire_reg && pre_ok)
                pend_next = 2'h1;
            else if (sh_next == SEQ_TO_SCAN && wire_reg && pre_ok)
                pend_next = 2'h2;
        end
    end

    // Run of highs ahead of the 16-bit pattern
    assign pre_ok = (pre_reg == 6'(SEQ_HIGH_MIN + 1));
    always_comb begin
        pre_next = pre_reg;
        if (tck_ev.rise && present_reg)
            pre_next = (sh_reg[15] && hi_reg == 6'(SEQ_HIGH_MIN + 1))
                       ? hi_reg : (sh_reg[15] ? pre_reg : 6'h00);
    end

    // TAP controller stepped by TCK rising edges; runs only in scan mode
    always_comb begin
        tap_next = tap_reg;
        if (tck_ev.rise && present_reg && !wire_reg) begin
            unique case (tap_reg)
                TAP_RESET:    tap_next = tms_lvl ? TAP_RESET   : TAP_IDLE;
                TAP_IDLE:     tap_next = tms_lvl ? TAP_SEL_DR  : TAP_IDLE;
                TAP_SEL_DR:   tap_next = tms_lvl ? TAP_SEL_IR  : TAP_CAP_DR;
                TAP_CAP_DR:   tap_next = tms_lvl ? TAP_EX1_DR  : TAP_SH_DR;
                TAP_SH_DR:    tap_next = tms_lvl ? TAP_EX1_DR  : TAP_SH_DR;
                TAP_EX1_DR:   tap_next = tms_lvl ? TAP_UPD_DR  : TAP_PAUSE_DR;
                TAP_PAUSE_DR: tap_next = tms_lvl ? TAP_EX2_DR  : TAP_PAUSE_DR;
                TAP_EX2_DR:   tap_next = tms_lvl ? TAP_UPD_DR  : TAP_SH_DR;
                TAP_UPD_DR:   tap_next = tms_lvl ? TAP_SEL_DR  : TAP_IDLE;
                TAP_SEL_IR:   tap_next = tms_lvl ? TAP_RESET   : TAP_CAP_IR;
                TAP_CAP_IR:   tap_next = tms_lvl ? TAP_EX1_IR  : TAP_SH_IR;
                TAP_SH_IR:    tap_next = tms_lvl ? TAP_EX1_IR  : TAP_SH_IR;
                TAP_EX1_IR:   tap_next = tms_lvl ? TAP_UPD_IR  : TAP_PAUSE_IR;
                TAP_PAUSE_IR: tap_next = tms_lvl ? TAP_EX2_IR  : TAP_PAUSE_IR;
                TAP_EX2_IR:   tap_next = tms_lvl ? TAP_UPD_IR  : TAP_SH_IR;
                TAP_UPD_IR:   tap_next = tms_lvl ? TAP_SEL_DR  : TAP_IDLE;
            endcase
        end
    end

    // Shared instruction register seen by both TAPs
    logic bscan_hit;
    always_comb begin
        irs_next = irs_reg;
        ir_next  = ir_reg;
        byp_next = byp_reg;
        if (front_rst) begin
            ir_next = IR_RESET_VAL;
        end else if (tck_ev.rise) begin
            if (tap_reg == TAP_CAP_IR)
                irs_next = 4'h1;
            else if (tap_reg == TAP_SH_IR)
                irs_next = {tdi_lvl, irs_reg[3:1]};
            else if (tap_reg == TAP_UPD_IR)
                ir_next = irs_reg;
            if (tap_reg == TAP_CAP_DR)
                byp_next = 1'b0;
            else if (tap_reg == TAP_SH_DR)
                byp_next = tdi_lvl;
        end
    end

    always_comb begin
        unique case (ir_reg)
            IR_EXTEST, IR_SAMPLE: bscan_hit = 1'b1;
            IR_INTEST, IR_CLAMP:  bscan_hit = 1'b1;
            default:              bscan_hit = 1'b0;
        endcase
    end

    // TDO mux: follows TRACE_SER_OUT every CLK in wire mode, else updated on falling TCK as JTAG requires
    always_comb begin
        tdo_next = tdo_reg;
        oe_next  = oe_reg;
        if (wire_reg) begin
            tdo_next = TRACE_SER_OUT;
            oe_next  = TRACE_EN;
        end else if (tck_ev.fall) begin
            oe_next = present_reg && (tap_reg == TAP_SH_DR || tap_reg == TAP_SH_IR);
            if (tap_reg == TAP_SH_IR)
                tdo_next = irs_reg[0];
            else if (bscan_hit && ir_reg == IR_CLAMP)
                tdo_next = byp_reg;
            else if (bscan_hit)
                tdo_next = byp_reg;
            else if (ir_reg == IR_BYPASS || ir_reg == IR_RSVD0 || ir_reg == IR_RSVD1)
                tdo_next = byp_reg;
            else
                tdo_next = DP_TDO;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            present_reg <= 1'b0;
            hold_reg    <= 1'b0;
            wire_reg    <= 1'b0;
            sh_reg      <= 16'h0000;
            hi_reg      <= 6'h00;
            pre_reg     <= 6'h00;
            pend_reg    <= 2'h0;
            post_reg    <= 6'h00;
            tap_reg     <= TAP_RESET;
            irs_reg     <= 4'h0;
            ir_reg      <= IR_RESET_VAL;
            byp_reg     <= 1'b0;
            tdo_reg     <= 1'b0;
            oe_reg      <= 1'b0;
        end else if (CE) begin
            present_reg <= present_next;
            hold_reg    <= hold_next;
            wire_reg    <= wire_next;
            sh_reg      <= sh_next;
            hi_reg      <= hi_next;
            pre_reg     <= pre_next;
            pend_reg    <= pend_next;
            post_reg    <= post_next;
            tap_reg     <= tap_next;
            irs_reg     <= irs_next;
            ir_reg      <= ir_next;
            byp_reg     <= byp_next;
            tdo_reg     <= tdo_next;
            oe_reg      <= oe_next;
        end
    end

    // Registered system-side indications
    logic       bus_sel_reg, mgr_sel_reg, clk_req_reg, pwr_reg, bsa_reg, scan_reg;
    logic [3:0] own_reg;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            bus_sel_reg <= 1'b0;
            mgr_sel_reg <= 1'b0;
            clk_req_reg <= 1'b0;
            pwr_reg     <= 1'b0;
            bsa_reg     <= 1'b0;
            own_reg     <= 4'h8;
            scan_reg    <= 1'b1;
        end else if (CE) begin
            bus_sel_reg <= (AP_SELECT == ACCESS_PORT_SELECT_BUS);
            mgr_sel_reg <= (AP_SELECT == ACCESS_PORT_SELECT_SYSMGR);
            clk_req_reg <= present_reg && !wire_reg && ir_reg == IR_APACC;
            pwr_reg     <= present_reg && !DEEP_SAVE;
            bsa_reg     <= !wire_reg && bscan_hit && !front_rst;
            scan_reg    <= ~wire_next;
            own_reg     <= {1'b1, present_reg, present_reg && !wire_reg,
                            present_reg && !wire_reg};
        end
    end

    assign TDO_OUT        = tdo_reg;
    assign TDO_OE         = oe_reg;
    assign BUS_AP_SEL     = bus_sel_reg;
    assign SYSMGR_AP_SEL  = mgr_sel_reg;
    assign PIN_OWN        = edf_pinown_type'(own_reg);
    assign SCAN_MODE      = scan_reg;
    assign DEBUG_PRESENT  = present_reg;
    assign CORE_RST_HOLD  = hold_reg;
    assign CPU_CLK_REQ    = clk_req_reg;
    assign POWER_KEEP     = pwr_reg;
    assign BSCAN_ACTIVE   = bsa_reg;
    assign IR_VALUE       = ir_reg;

    // Checks
    present_on_fall_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && tck_ev.fall && rst_lvl && !DEEP_SAVE |=> present_reg)
        else $error("debugger not detected on TCK fall");
    deep_no_detect_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && DEEP_SAVE && !present_reg |=> !present_reg)
        else $error("debugger detected in deepest save mode");
    hold_on_release_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && rst_ev.rise && !tck_lvl |=> hold_reg)
        else $error("core reset request missing");
    hold_kept_a: assert property (@(posedge CLK) disable iff (!RST_N)
        hold_reg && !SYSMGR_REQ_CLR |=> hold_reg)
        else $error("core reset released early");
    tap_reset_ir_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && front_rst |=> ir_reg == IR_RESET_VAL)
        else $error("instruction not reset in TLR");
    wire_no_bscan_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && wire_reg |=> !bsa_reg)
        else $error("boundary scan active in wire mode");
    wire_pins_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && wire_reg ##1 wire_reg |-> !own_reg[0] && !own_reg[1])
        else $error("TDI/TDO not released");
    access_port_select_map_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && AP_SELECT == ACCESS_PORT_SELECT_SYSMGR |=> mgr_sel_reg && !bus_sel_reg)
        else $error("access port select misrouted");
    power_keep_a: assert property (@(posedge CLK) disable iff (!RST_N)
        CE && present_reg && !DEEP_SAVE |=> pwr_reg)
        else $error("power not kept");
    mode_reset_a: assert property (@(posedge CLK)
        !RST_N |=> !wire_reg)
        else $error("not in scan mode after reset");

    cov_detect_c: cover property (@(posedge CLK) !present_reg ##1 present_reg);
    cov_wire_c:   cover property (@(posedge CLK) !wire_reg ##1 wire_reg);
    cov_hold_c:   cover property (@(posedge CLK) hold_reg ##1 !hold_reg);
    cov_bscan_c:  cover property (@(posedge CLK) bsa_reg);

endmodule : edf_front

/* edf_front_tb.sv */
// Self-checking bench for the debug port front end.
// Assumes edf_pkg and edf_probe are compiled first; CLK is 250 MHz.
module edf_front_tb
    import edf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic [3:0] ir;
        logic [7:0] ap;
        logic       bscan;
        logic       cpu;
        logic       chk;
        logic       tdo;
    } edf_row_type;

    localparam edf_row_type ROWS [11] = '{
        '{IR_EXTEST, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0}, '{IR_SAMPLE, 8'h01, 1'b1, 1'b0, 1'b0, 1'b0},
        '{IR_INTEST, 8'h02, 1'b1, 1'b0, 1'b0, 1'b0}, '{IR_CLAMP,  8'h00, 1'b1, 1'b0, 1'b1, 1'b0},
        '{IR_ABORT,  8'h01, 1'b0, 1'b0, 1'b1, 1'b1}, '{IR_DPACC,  8'h00, 1'b0, 1'b0, 1'b1, 1'b1},
        '{IR_APACC,  8'h01, 1'b0, 1'b1, 1'b1, 1'b1}, '{IR_RSVD0,  8'h00, 1'b0, 1'b0, 1'b1, 1'b0},
        '{IR_RSVD1,  8'h01, 1'b0, 1'b0, 1'b1, 1'b0}, '{IR_IDCODE, 8'h00, 1'b0, 1'b0, 1'b1, 1'b1},
        '{IR_BYPASS, 8'h01, 1'b0, 1'b0, 1'b1, 1'b0}};

    logic           clk;
    logic           rst_n;
    logic           tck;
    logic           tms;
    logic           tdi;
    logic           rst_pin_n;
    logic           tdo_out;
    logic           tdo_oe;
    logic           dp_tdo;
    logic           trace_ser_out;
    logic           trace_en;
    logic           sysmgr_req_clr;
    logic [7:0]     ap_select;
    logic           deep_save;
    logic           bus_ap_sel;
    logic           sysmgr_ap_sel;
    edf_pinown_type pin_own;
    logic           scan_mode;
    logic           debug_present;
    logic           core_rst_hold;
    logic           cpu_clk_req;
    logic           power_keep;
    logic           bscan_active;
    logic [3:0]     ir_value;
    int             num_errors = 0;
    int             checks_done = 0;

    edf_front edf_front_i (.CLK(clk), .RST_N(rst_n), .CE(1'b1), .TCK(tck), .TMS_IN(tms), .TDI(tdi),
        .RESET_PIN_N(rst_pin_n), .TDO_OUT(tdo_out), .TDO_OE(tdo_oe), .DP_TDO(dp_tdo),
        .TRACE_SER_OUT(trace_ser_out), .TRACE_EN(trace_en), .SYSMGR_REQ_CLR(sysmgr_req_clr),
        .AP_SELECT(ap_select), .DEEP_SAVE(deep_save), .BUS_AP_SEL(bus_ap_sel), .SYSMGR_AP_SEL(sysmgr_ap_sel),
        .PIN_OWN(pin_own), .SCAN_MODE(scan_mode), .DEBUG_PRESENT(debug_present), .CORE_RST_HOLD(core_rst_hold),
        .CPU_CLK_REQ(cpu_clk_req), .POWER_KEEP(power_keep), .BSCAN_ACTIVE(bscan_active), .IR_VALUE(ir_value));

    edf_probe edf_probe_i (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .rst_pin_n(rst_pin_n), .tdo(tdo_out),
        .tdo_oe(tdo_oe));

    always #2 clk = ~clk;

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected 34 us of traffic
    initial begin
        #200000;
        num_errors++;
        end_sim();
    end

    initial begin
        logic q;
        clk = 1'b0;
        rst_n = 1'b0;
        dp_tdo = 1'b1;
        trace_ser_out = 1'b0;
        trace_en = 1'b0;
        sysmgr_req_clr = 1'b0;
        ap_select = 8'h00;
        deep_save = 1'b0;
        repeat (6) @(negedge clk);
        check(pin_own, 4'h8);
        check(4'(scan_mode), 4'h1);
        check(ir_value, IR_RESET_VAL);
        check(4'(debug_present), 4'h0);
        check(4'(tdo_oe), 4'h0);
        rst_n = 1'b1;
        $display("test reset done");
        // Core reset request while TCK stays low
        wait_clk(4);
        edf_probe_i.set_rst(1'b1);
        for (int i = 0; i < 20 && core_rst_hold !== 1'b1; i++) @(negedge clk);
        check(4'(core_rst_hold), 4'h1);
        wait_clk(30);
        check(4'(core_rst_hold), 4'h1);
        check(4'(debug_present), 4'h0);
        sysmgr_req_clr = 1'b1;
        wait_clk(2);
        sysmgr_req_clr = 1'b0;
        wait_clk(3);
        check(4'(core_rst_hold), 4'h0);
        $display("test core reset done");
        // Hot plug blocked in deepest save mode
        deep_save = 1'b1;
        edf_probe_i.edge_pair();
        check(4'(debug_present), 4'h0);
        deep_save = 1'b0;
        edf_probe_i.edge_pair();
        check(4'(debug_present), 4'h1);
        check(pin_own, 4'hF);
        check(4'(power_keep), 4'h1);
        check(4'(core_rst_hold), 4'h0);
        $display("test hot plug done");
        edf_probe_i.tap_reset();
        foreach (ROWS[i]) begin
            ap_select = ROWS[i].ap;
            edf_probe_i.load_ir(ROWS[i].ir);
            wait_clk(6);
            check(ir_value, ROWS[i].ir);
            check(4'(bscan_active), 4'(ROWS[i].bscan));
            check(4'(cpu_clk_req), 4'(ROWS[i].cpu));
            check(4'(bus_ap_sel), 4'(ROWS[i].ap == ACCESS_PORT_SELECT_BUS));
            check(4'(sysmgr_ap_sel), 4'(ROWS[i].ap == ACCESS_PORT_SELECT_SYSMGR));
            if (ROWS[i].chk) begin
                edf_probe_i.shift_dr(q);
                check(4'(q), 4'(ROWS[i].tdo));
            end
        end
        $display("test instructions done");
        edf_probe_i.tap_reset();
        wait_clk(4);
        check(ir_value, IR_RESET_VAL);
        // Serial wire mode and trace output
        edf_probe_i.switch_seq(SEQ_TO_WIRE);
        wait_clk(4);
        check(4'(scan_mode), 4'h0);
        check(4'(pin_own.tdi_own), 4'h0);
        check(4'(bscan_active), 4'h0);
        trace_en = 1'b1;
        trace_ser_out = 1'b1;
        wait_clk(4);
        check(4'(tdo_out), 4'h1);
        check(4'(tdo_oe), 4'h1);
        trace_ser_out = 1'b0;
        wait_clk(4);
        check(4'(tdo_out), 4'h0);
        edf_probe_i.load_ir(IR_CLAMP);
        wait_clk(4);
        check(4'(bscan_active), 4'h0);
        check(ir_value, IR_RESET_VAL);
        trace_en = 1'b0;
        edf_probe_i.switch_seq(SEQ_TO_SCAN);
        wait_clk(4);
        check(4'(scan_mode), 4'h1);
        check(4'(pin_own.tdi_own), 4'h1);
        $display("test mode switch done");
        edf_probe_i.set_rst(1'b0);
        wait_clk(8);
        check(4'(debug_present), 4'h0);
        $display("test presence drop done");
        end_sim();
    end

endmodule // edf_front_tb

/* edf_pkg.sv */
// Shared constants and types for the debug port front end.
// Assumes a single 250 MHz system clock; link pins arrive asynchronously.
package edf_pkg;

    // Instruction register width and codes
    localparam int          IR_W           = 4;
    localparam logic [3:0]  IR_EXTEST      = 4'h0;
    localparam logic [3:0]  IR_SAMPLE      = 4'h1;
    localparam logic [3:0]  IR_INTEST      = 4'h4;
    localparam logic [3:0]  IR_CLAMP       = 4'h5;
    localparam logic [3:0]  IR_ABORT       = 4'h8;
    localparam logic [3:0]  IR_DPACC       = 4'hA;
    localparam logic [3:0]  IR_APACC       = 4'hB;
    localparam logic [3:0]  IR_RSVD0       = 4'hC;
    localparam logic [3:0]  IR_RSVD1       = 4'hD;
    localparam logic [3:0]  IR_IDCODE      = 4'hE;
    localparam logic [3:0]  IR_BYPASS      = 4'hF;
    localparam logic [3:0]  IR_RESET_VAL   = 4'hE;

    // Mode switch sequences
    localparam logic [15:0] SEQ_TO_WIRE    = 16'h79E7;
    localparam logic [15:0] SEQ_TO_SCAN    = 16'h3CE7;
    localparam int          SEQ_HIGH_MIN   = 50;
    localparam int          SEQ_CNT_W      = 6;

    // Access port select values
    localparam logic [7:0]  ACCESS_PORT_SELECT_BUS      = 8'h00;
    localparam logic [7:0]  ACCESS_PORT_SELECT_SYSMGR   = 8'h01;

    // TCK cycles a probe should keep TMS high after detection
    localparam int          TMS_RESET_TCKS = 5;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
        TAP_PAUSE_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
        TAP_SH_IR, TAP_EX1_IR, TAP_PAUSE_IR, TAP_EX2_IR, TAP_UPD_IR
    } edf_tap_type;

    // Pin ownership and mux indications
    typedef struct packed {
        logic tck_own;
        logic tms_own;
        logic tdi_own;
        logic tdo_own;
    } edf_pinown_type;

    // Edge events seen on a synchronised pin (TCK and the reset pin)
    typedef struct packed {
        logic rise;
        logic fall;
    } edf_edge_type;

endpackage : edf_pkg

/* edf_probe.sv */
// Behavioural model of the external debug probe driving the debug pins.
// Assumes it is paced by the bench's system clock; one TCK period is 20 CLK.
module edf_probe
    import edf_pkg::*;
(
    // Pacing clock
    input  wire logic clk,
    // Probe pins
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      rst_pin_n,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    // TCK held low while the reset pin is asserted
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        rst_pin_n = 1'b0;
    end

    task automatic half();
        repeat (10) @(negedge clk);
    endtask

    // One TCK period, pins change in the low phase, TDO taken before the rise
    task automatic bit_io(input logic m, input logic d, output logic q);
        tck = 1'b0;
        tms = m;
        tdi = d;
        half();
        // Undriven TDO reads back as the opposite of its last value
        q = tdo_oe ? tdo : ~tdo;
        tck = 1'b1;
        half();
    endtask

    // Unused TDI toggles so a stale value is never mistaken for data
    task automatic bit_o(input logic m);
        logic q;
        bit_io(m, ~tdi, q);
    endtask

    task automatic tap_reset();
        repeat (TMS_RESET_TCKS) bit_o(1'b1);
        bit_o(1'b0);
    endtask

    task automatic load_ir(input logic [3:0] code);
        logic q;
        bit_o(1'b1);
        bit_o(1'b1);
        bit_o(1'b0);
        bit_o(1'b0);
        for (int i = 0; i < IR_W; i++) begin
            bit_io(i == IR_W - 1, code[i], q);
        end
        bit_o(1'b1);
        bit_o(1'b0);
    endtask

    // First captured bit of the data register, then back to idle
    task automatic shift_dr(output logic q);
        bit_o(1'b1);
        bit_o(1'b0);
        bit_o(1'b0);
        bit_io(1'b1, 1'b1, q);
        bit_o(1'b1);
        bit_o(1'b0);
    endtask

    task automatic switch_seq(input logic [15:0] pat);
        repeat (SEQ_HIGH_MIN + 1) bit_o(1'b1);
        for (int i = 15; i >= 0; i--) begin
            bit_o(pat[i]);
        end
        repeat (SEQ_HIGH_MIN + 1) bit_o(1'b1);
    endtask

    task automatic edge_pair();
        tck = 1'b1;
        half();
        tck = 1'b0;
        half();
    endtask

    task automatic set_rst(input logic v);
        rst_pin_n = v;
    endtask

endmodule // edf_probe

/* edf_sync.sv */
// Two-stage synchroniser with edge detection on the synchronised level.
// Assumes input is asynchronous to CLK.
module edf_sync
    import edf_pkg::*;
(
    // Clock and control
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // Data
    input  wire logic         async_in,
    output logic              level,
    output edf_edge_type      edge_ev
);

    logic s1_reg, s2_reg, s3_reg;
    logic s1_next, s2_next, s3_next;
    // Edges held off until the stages hold real pin samples, not reset values
    logic [1:0] fill_reg, fill_next;

    always_comb begin
        s1_next = s1_reg;
        s2_next = s2_reg;
        s3_next = s3_reg;
        fill_next = fill_reg;
        if (ce) begin
            s1_next = async_in;
            s2_next = s1_reg;
            s3_next = s2_reg;
            if (fill_reg != 2'h3)
                fill_next = fill_reg + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            fill_reg <= 2'h0;
        end else begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            fill_reg <= fill_next;
        end
    end

    assign level   = s2_reg;
    assign edge_ev = {ce & (fill_reg == 2'h3) & s2_reg & ~s3_reg,
                      ce & (fill_reg == 2'h3) & ~s2_reg & s3_reg};

endmodule : edf_sync
